// file: rtl/cimb_id_mask_msg_buf.sv
// Identifier mask registers, acceptance filter and message buffer storage.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "cimb_params.svh"

// Summary of operation
// - Mask bit one ignores that code bit.
// - Mask bit zero demands code equals identifier.
// - Accept only when all unmasked bits match.
// - Masks always readable; written only in init.
// - Each buffer: 16-byte window, 13 data bytes.
// - Stamp enabled: store timer at message end.
// - Time stamp bytes read-only to software.
// - Fixed byte layout inside each buffer window.
// - Priority byte only in transmit buffer.
// - Buffer RAM unreset; priority resets zero.
// - Unused buffer bits read unspecified.
// - Extended identifier bit layout in bytes 0-3.
// - Compare code with identifier, qualify by mask.
// - Standard uses two bytes, extended four.
// - Arrangement: 2x32, 4x16, 8x8, or closed.
// - Length code gives zero to eight bytes.
module cimb_id_mask_msg_buf (
  input wire logic core_clk, // Module clock, 125 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire cimb_pkg::cimb_axi_req_t axiReq, // AXI4-Lite master to slave signals.
  output cimb_pkg::cimb_axi_rsp_t axiRsp, // AXI4-Lite slave to master signals.
  input wire logic initAcknowledge, // Init mode acknowledge from mode control.
  output logic initRequest, // Init mode request to mode control.
  output logic stampEnable, // Time-stamp enable to the bit engine.
  input wire logic [15:0] stampTimer, // Free-running bit timer value.
  input wire logic msgDone, // Pulse: message acknowledged on the bus.
  input wire logic msgIsTx, // With msgDone: stamp goes to transmit buffer.
  input wire cimb_pkg::cimb_rx_ident_t rxIdent, // Received identifier bytes, valid pulse.
  output cimb_pkg::cimb_hit_t filterHit, // Filter result, registered.
  output logic filterValid, // Pulse: filterHit updated.
  output logic [3:0] txLengthCode, // Transmit data byte count, 0 to 8.
  output logic [31:0] txIdent // Transmit identifier bytes 0 to 3.
);
  import cimb_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] mask;
    logic [7:0][7:0] code;
    logic stampEn;
    logic initReq;
    cimb_arr_t arr;
    logic [7:0] txPriority;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    cimb_hit_t hit;
    logic hitValid;
  } cimb_state_t;

  cimb_state_t st;
  cimb_state_t next_st;

  // ******************************************************
  // Buffer RAM, no reset on contents
  // ******************************************************
  logic [7:0] txBuf [0:`CIMB_BUF_BYTES-1];
  logic [7:0] rxBuf [0:`CIMB_BUF_BYTES-1];

  logic initMode;
  logic wrFire;
  logic rdFire;
  logic [7:0] wIdx;
  logic [7:0] rIdx;
  logic [7:0] wByte;
  logic [3:0] wOfs;
  logic [3:0] rOfs;
  logic [7:0][7:0] bitMatch;
  logic [7:0] byteOk;
  logic [7:0] hits;
  logic isExt;

  assign initMode = st.initReq & initAcknowledge;
  assign wrFire = st.awHeld & st.wHeld & ~st.bValid;
  assign rdFire = axiReq.arvalid & ~st.rValid;
  assign wIdx = {2'b00, st.awAddr[7:2]};
  assign rIdx = {2'b00, axiReq.araddr[7:2]};
  assign wByte = st.wData[7:0];
  assign wOfs = wIdx[3:0];
  assign rOfs = rIdx[3:0];

  // ******************************************************
  // Acceptance filter
  // ******************************************************
  assign isExt = rxIdent.ident[19];
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      // Byte b of a filter is compared with identifier byte b mod 4.
      bitMatch[b] = st.mask[b] | ~(st.code[b] ^ rxIdent.ident[31-8*(b%4) -: 8]);
      byteOk[b] = &bitMatch[b];
    end
  end

  always_comb begin
    hits = 8'h00;
    case (st.arr)
      CIMB_ARR_TWO32: begin
        for (int f = 0; f < 2; f++) begin
          hits[f] = byteOk[4*f] & byteOk[4*f+1] &
            (~isExt | (byteOk[4*f+2] & byteOk[4*f+3]));
        end
      end
      CIMB_ARR_FOUR16: begin
        for (int f = 0; f < 4; f++) begin
          hits[f] = byteOk[2*f] & byteOk[2*f+1];
        end
      end
      CIMB_ARR_EIGHT8: begin
        hits = byteOk;
      end
      CIMB_ARR_CLOSED: begin
        hits = 8'h00;
      end
      default: begin
        hits = 8'h00;
      end
    endcase
  end

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    next_st = st;
    next_st.hitValid = 1'b0;
    if (rxIdent.valid) begin
      next_st.hitValid = 1'b1;
      next_st.hit.hit = |hits;
      next_st.hit.filter = 3'h0;
      for (int f = 7; f >= 0; f--) begin
        if (hits[f]) begin
          next_st.hit.filter = 3'(f);
        end
      end
    end
    if (axiReq.awvalid & ~st.awHeld) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid & ~st.wHeld) begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
    end
    if (st.bValid & axiReq.bready) begin
      next_st.bValid = 1'b0;
    end
    if (wrFire) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = `CIMB_RESP_OKAY;
      if (wIdx == `CIMB_CTRL_INDEX) begin
        if (st.wStrb[0]) begin
          next_st.stampEn = st.wData[`CIMB_CTRL_STAMP_EN_BIT];
          next_st.initReq = st.wData[`CIMB_CTRL_INIT_REQ_BIT];
          next_st.arr = cimb_arr_t'(st.wData[`CIMB_CTRL_ARR_LSB +: 2]);
        end
      end else if (wIdx >= `CIMB_ID_CODE_BYTE0 && wIdx <= `CIMB_ID_MASK_BYTE7) begin
        // Code and mask bytes only change in init mode.
        if (st.wStrb[0] & initMode) begin
          if (wIdx >= `CIMB_ID_MASK_BYTE4) begin
            next_st.mask[wIdx[1:0] + 3'd4] = wByte;
          end else if (wIdx >= `CIMB_ID_CODE_BYTE4) begin
            next_st.code[wIdx[1:0] + 3'd4] = wByte;
          end else if (wIdx >= `CIMB_ID_MASK_BYTE0) begin
            next_st.mask[wIdx[1:0]] = wByte;
          end else begin
            next_st.code[wIdx[1:0]] = wByte;
          end
        end
      end else if (wIdx == `CIMB_TX_BUF_INDEX + `CIMB_OFS_PRIORITY) begin
        if (st.wStrb[0]) begin
          next_st.txPriority = wByte;
        end
      end else if (wIdx[7:4] == `CIMB_TX_BUF_INDEX >> 4 ||
                   wIdx[7:4] == `CIMB_RX_BUF_INDEX >> 4) begin
        next_st.bResp = `CIMB_RESP_OKAY;
      end else begin
        next_st.bResp = `CIMB_RESP_SLVERR;
      end
    end
    if (st.rValid & axiReq.rready) begin
      next_st.rValid = 1'b0;
    end
    if (rdFire) begin
      next_st.rValid = 1'b1;
      next_st.rResp = `CIMB_RESP_OKAY;
      next_st.rData = 32'h0000_0000;
      if (rIdx == `CIMB_CTRL_INDEX) begin
        next_st.rData[4:0] = {st.arr, st.initReq, st.stampEn};
      end else if (rIdx == `CIMB_STATUS_INDEX) begin
        next_st.rData[4:0] = {st.hit, initMode};
      end else if (rIdx >= `CIMB_ID_MASK_BYTE4 && rIdx <= `CIMB_ID_MASK_BYTE7) begin
        next_st.rData[7:0] = st.mask[rIdx[1:0] + 3'd4];
      end else if (rIdx >= `CIMB_ID_CODE_BYTE4 && rIdx < `CIMB_ID_MASK_BYTE4) begin
        next_st.rData[7:0] = st.code[rIdx[1:0] + 3'd4];
      end else if (rIdx >= `CIMB_ID_MASK_BYTE0 && rIdx < `CIMB_ID_CODE_BYTE4) begin
        next_st.rData[7:0] = st.mask[rIdx[1:0]];
      end else if (rIdx >= `CIMB_ID_CODE_BYTE0 && rIdx < `CIMB_ID_MASK_BYTE0) begin
        next_st.rData[7:0] = st.code[rIdx[1:0]];
      end else if (rIdx == `CIMB_TX_BUF_INDEX + `CIMB_OFS_PRIORITY) begin
        next_st.rData[7:0] = st.txPriority;
      end else if (rIdx[7:4] == `CIMB_TX_BUF_INDEX >> 4) begin
        next_st.rData[7:0] = txBuf[rOfs];
      end else if (rIdx[7:4] == `CIMB_RX_BUF_INDEX >> 4) begin
        next_st.rData[7:0] = rxBuf[rOfs];
      end else begin
        next_st.rResp = `CIMB_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mask <= {8{`CIMB_MASK_RESET}};
      st.txPriority <= `CIMB_PRIORITY_RESET;
      st.arr <= CIMB_ARR_TWO32;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************
  // Buffer writes: software data bytes, hardware stamps and received identifier bytes
  // ******************************************************
  always_ff @(posedge core_clk) begin
    if (wrFire && st.wStrb[0] && wIdx[7:4] == `CIMB_TX_BUF_INDEX >> 4 &&
        wOfs < `CIMB_OFS_PRIORITY + 4'h0) begin
      // Stamp and priority bytes are not written from software here.
      txBuf[wOfs] <= wByte;
    end
    // Software never reaches the stamp bytes, so a stamp is never lost to a bus write.
    if (msgDone && stampEnable && msgIsTx) begin
      txBuf[`CIMB_OFS_STAMP_HIGH] <= stampTimer[15:8];
      txBuf[`CIMB_OFS_STAMP_LOW] <= stampTimer[7:0];
    end
    if (msgDone && stampEnable && !msgIsTx) begin
      rxBuf[`CIMB_OFS_STAMP_HIGH] <= stampTimer[15:8];
      rxBuf[`CIMB_OFS_STAMP_LOW] <= stampTimer[7:0];
    end
    if (rxIdent.valid) begin
      for (int i = 0; i < 4; i++) begin
        rxBuf[i] <= rxIdent.ident[31-8*i -: 8];
      end
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign axiRsp.awready = ~st.awHeld;
  assign axiRsp.wready = ~st.wHeld;
  assign axiRsp.bvalid = st.bValid;
  assign axiRsp.bresp = st.bResp;
  assign axiRsp.arready = ~st.rValid;
  assign axiRsp.rvalid = st.rValid;
  assign axiRsp.rdata = st.rData;
  assign axiRsp.rresp = st.rResp;
  assign initRequest = st.initReq;
  assign stampEnable = st.stampEn;
  assign filterHit = st.hit;
  assign filterValid = st.hitValid;
  // Only the low four bits carry the code; counts above eight clip to eight.
  assign txLengthCode = (txBuf[`CIMB_OFS_LENGTH][3:0] > `CIMB_LENGTH_CODE_MAX) ?
    `CIMB_LENGTH_CODE_MAX : txBuf[`CIMB_OFS_LENGTH][3:0];
  assign txIdent = {txBuf[0], txBuf[1], txBuf[2], txBuf[3]};
endmodule // cimb_id_mask_msg_buf

// file: rtl/cimb_params.svh
// Register offsets, field positions, reset values and sizes for the mask and buffer block.
`ifndef CIMB_PARAMS_SVH
`define CIMB_PARAMS_SVH
`define CIMB_ID_MASK_BYTE0 8'h14
`define CIMB_ID_MASK_BYTE1 8'h15
`define CIMB_ID_MASK_BYTE2 8'h16
`define CIMB_ID_MASK_BYTE3 8'h17
`define CIMB_ID_MASK_BYTE4 8'h1c
`define CIMB_ID_MASK_BYTE5 8'h1d
`define CIMB_ID_MASK_BYTE6 8'h1e
`define CIMB_ID_MASK_BYTE7 8'h1f
`define CIMB_ID_CODE_BYTE0 8'h10
`define CIMB_ID_CODE_BYTE4 8'h18
`define CIMB_CTRL_INDEX 8'h08
`define CIMB_STATUS_INDEX 8'h09
`define CIMB_TX_BUF_INDEX 8'h20
`define CIMB_RX_BUF_INDEX 8'h30
`define CIMB_OFS_LENGTH 4'hc
`define CIMB_OFS_PRIORITY 4'hd
`define CIMB_OFS_STAMP_HIGH 4'he
`define CIMB_OFS_STAMP_LOW 4'hf
`define CIMB_BUF_BYTES 16
`define CIMB_BUF_DATA_BYTES 13
`define CIMB_MASK_RESET 8'h00
`define CIMB_PRIORITY_RESET 8'h00
`define CIMB_LENGTH_CODE_MAX 4'h8
`define CIMB_CTRL_STAMP_EN_BIT 0
`define CIMB_CTRL_INIT_REQ_BIT 1
`define CIMB_CTRL_ARR_LSB 2
`define CIMB_RESP_OKAY 2'b00
`define CIMB_RESP_SLVERR 2'b10
`endif

// file: rtl/cimb_pkg.sv
// Types shared by the mask and message buffer block.
package cimb_pkg;
  typedef enum logic [1:0] {
    CIMB_ARR_TWO32,
    CIMB_ARR_FOUR16,
    CIMB_ARR_EIGHT8,
    CIMB_ARR_CLOSED
  } cimb_arr_t;
  typedef struct packed {
    logic valid;
    logic [31:0] ident;
  } cimb_rx_ident_t;
  typedef struct packed {
    logic hit;
    logic [2:0] filter;
  } cimb_hit_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } cimb_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cimb_axi_rsp_t;
endpackage

// file: tb/cimb_can_side.sv
// Far-side model: mode control, bit timer and message end events.
`timescale 1ns/100ps
module cimb_can_side (
  input wire logic core_clk, // Module clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic initRequest, // Init request from the block.
  output logic initAcknowledge, // Init acknowledge, two cycles late.
  output logic [15:0] stampTimer, // Free-running bit timer.
  input wire logic doneCmd, // Bench asks for one message end.
  input wire logic txCmd, // Bench picks transmit or receive for the end.
  output logic msgDone, // One-cycle message end pulse.
  output logic msgIsTx, // Message was a transmission.
  output logic [15:0] lastStamp // Timer value seen with msgDone.
);
  logic ackDly;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ackDly, initAcknowledge, stampTimer, msgDone, msgIsTx, lastStamp} <= '0;
    end else begin
      ackDly <= initRequest;
      initAcknowledge <= ackDly;
      stampTimer <= stampTimer + 16'h0001;
      msgDone <= doneCmd && !msgDone;
      msgIsTx <= txCmd;
      if (msgDone) begin
        lastStamp <= stampTimer;
      end
    end
  end
endmodule // cimb_can_side

// file: tb/cimb_id_mask_msg_buf_props.sv
// Port checks of the mask and buffer block.
`timescale 1ns/100ps
module cimb_id_mask_msg_buf_props (
  input wire logic core_clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire cimb_pkg::cimb_axi_req_t axiReq, // Bus request.
  input wire cimb_pkg::cimb_axi_rsp_t axiRsp, // Bus answer.
  input wire logic stampEnable, // Stamp enable.
  input wire logic initRequest, // Init request.
  input wire cimb_pkg::cimb_rx_ident_t rxIdent, // Identifier in.
  input wire cimb_pkg::cimb_hit_t filterHit, // Filter result.
  input wire logic filterValid, // Result strobe.
  input wire logic [31:0] txIdent // Transmit identifier.
);
  import cimb_pkg::*;
  // ********
  // Assertions.
  // ********
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  filt_valid_a: assert property (rxIdent.valid |=> filterValid)
    else $error("filter strobe missing");
  filt_cause_a: assert property (filterValid |-> $past(rxIdent.valid))
    else $error("filter strobe without identifier");
  filt_hold_a: assert property (!rxIdent.valid |=> $stable(filterHit))
    else $error("filter result moved alone");
  rd_lat_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=>
    axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read answer dropped");
  b_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid)
    else $error("write answer dropped");
  ctrl_write_a: assert property ($changed(stampEnable) || $changed(initRequest)
    |-> axiRsp.bvalid) else $error("control moved without write");
  tx_ident_a: assert property ($changed(txIdent) |-> axiRsp.bvalid)
    else $error("transmit identifier moved without write");
  cover property (filterValid && filterHit.hit);
  cover property (axiRsp.rvalid && axiRsp.rresp == 2'b10);
  cover property ($rose(stampEnable));
endmodule // cimb_id_mask_msg_buf_props
bind cimb_id_mask_msg_buf cimb_id_mask_msg_buf_props u_props (.core_clk(core_clk),
  .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp), .stampEnable(stampEnable),
  .initRequest(initRequest), .rxIdent(rxIdent), .filterHit(filterHit),
  .filterValid(filterValid), .txIdent(txIdent));

// file: tb/cimb_id_mask_msg_buf_test.sv
// Self-checking bench of the mask and buffer block.
`timescale 1ns/100ps
module cimb_id_mask_msg_buf_test;
  import cimb_pkg::*;
  logic core_clk = 0, rst_n = 0, doneCmd = 0, txCmd = 1;
  cimb_axi_req_t axiReq = '0;
  cimb_axi_rsp_t axiRsp, rsp;
  cimb_rx_ident_t rxIdent = '0;
  cimb_hit_t filterHit;
  logic initAck, initReq, stampEn, msgDone, msgIsTx, filterValid;
  logic [15:0] timer, lastStamp;
  logic [3:0] txLen;
  logic [31:0] txIdent;
  int fails = 0, n_compared = 0, cyc = 0;
  always #4 core_clk = ~core_clk;
  cimb_id_mask_msg_buf u_cimb_id_mask_msg_buf (.core_clk(core_clk), .rst_n(rst_n),
    .axiReq(axiReq), .axiRsp(axiRsp), .initAcknowledge(initAck), .initRequest(initReq),
    .stampEnable(stampEn), .stampTimer(timer), .msgDone(msgDone), .msgIsTx(msgIsTx),
    .rxIdent(rxIdent), .filterHit(filterHit), .filterValid(filterValid),
    .txLengthCode(txLen), .txIdent(txIdent));
  cimb_can_side u_cimb_can_side (.core_clk(core_clk), .rst_n(rst_n), .initRequest(initReq),
    .initAcknowledge(initAck), .stampTimer(timer), .doneCmd(doneCmd), .txCmd(txCmd),
    .msgDone(msgDone),
    .msgIsTx(msgIsTx), .lastStamp(lastStamp));
  // ********
  // Bus cycles and comparison.
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
    axiReq <= {1'b1, idx[5:0], 2'b00, 1'b1, 24'h0, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    do begin
      @(negedge core_clk) rsp = axiRsp;
      @(posedge core_clk);
      if (rsp.awready) axiReq.awvalid <= 1'b0;
      if (rsp.wready) axiReq.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    axiReq.bready <= 1'b0;
    check({30'h0, rsp.bresp}, {30'h0, er});
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {idx[5:0], 2'b00};
    axiReq.rready <= 1'b1;
    do begin
      @(negedge core_clk) rsp = axiRsp;
      @(posedge core_clk);
      if (rsp.arready) axiReq.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    axiReq.rready <= 1'b0;
    check(rsp.rdata, exp);
    check({30'h0, rsp.rresp}, {30'h0, er});
    @(posedge core_clk);
  endtask
  task automatic sendId(input logic [31:0] id, input logic [3:0] exp);
    rxIdent <= {1'b1, id};
    @(posedge core_clk);
    rxIdent.valid <= 1'b0;
    @(negedge core_clk);
    check({31'h0, filterValid}, 32'h1);
    check(filterHit.hit ? {28'h0, filterHit} : 32'h0, {28'h0, exp});
    @(posedge core_clk);
  endtask
  // ********
  // Scenarios.
  // ********
  task automatic testReset;
    for (int i = 0; i < 8; i++) rdc((i < 4 ? 8'h14 : 8'h18) + 8'(i), 32'h0);
    rdc(8'h2d, 32'h0);
    rdc(8'h00, 32'h0, 2'b10);
    wr(8'h00, 8'h00, 2'b10);
    $display("testReset done");
  endtask
  task automatic testInit;
    wr(8'h14, 8'ha5);
    rdc(8'h14, 32'h0);
    wr(8'h08, 8'h03);
    while (!initAck) @(posedge core_clk);
    wr(8'h14, 8'ha5);
    rdc(8'h14, 32'ha5);
    wr(8'h14, 8'h00);
    $display("testInit done");
  endtask
  task automatic testFilter;
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i), 8'h12 + 8'(i) * 8'h22);
    wr(8'h11, 8'h3c);
    sendId(32'h123c5678, 4'h8);
    sendId(32'h123c5679, 4'h0);
    wr(8'h17, 8'h01);
    sendId(32'h123c5679, 4'h8);
    wr(8'h11, 8'h20);
    wr(8'h15, 8'h07);
    sendId(32'h1227aaaa, 4'h8);
    for (int m = 1; m < 3; m++) begin
      wr(8'h08, {4'h0, 2'(m), 2'b11});
      sendId(32'h1227aaaa, 4'h8);
    end
    wr(8'h08, 8'h0f);
    sendId(32'h1227aaaa, 4'h0);
    $display("testFilter done");
  endtask
  task automatic testBuffer;
    for (int i = 0; i < 4; i++) wr(8'h20 + 8'(i), 8'h12 + 8'(i) * 8'h22);
    check(txIdent, 32'h12345678);
    wr(8'h2c, 8'hf5);
    check({28'h0, txLen}, 32'h5);
    wr(8'h2c, 8'h08);
    check({28'h0, txLen}, 32'h8);
    wr(8'h2d, 8'h3a);
    rdc(8'h2d, 32'h3a);
    wr(8'h2b, 8'h5c);
    rdc(8'h2b, 32'h5c);
    for (int k = 0; k < 2; k++) begin
      txCmd <= (k == 0);
      doneCmd <= 1'b1;
      @(posedge core_clk);
      doneCmd <= 1'b0;
      repeat (3) @(posedge core_clk);
      wr(8'h2e + 8'(16 * k), ~lastStamp[15:8]);
      rdc(8'h2e + 8'(16 * k), {24'h0, lastStamp[15:8]});
      rdc(8'h2f + 8'(16 * k), {24'h0, lastStamp[7:0]});
    end
    $display("testBuffer done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    testReset;
    testInit;
    testFilter;
    testBuffer;
    end_of_test;
  end
endmodule // cimb_id_mask_msg_buf_test
